// >>> logic/lvds_cmos_channel_dividers.sv
// Purpose: Two output channels, each two cascaded divider stages,
//          with bypass, phase offset, start level, sync and force.
// Assumes: dist_clk_i is the distribution clock, far slower than
//          sys_clk_i; sync_n_i is the chip-level sync, active low.
// Notes:   Both inputs are pins and pass a three-flop filter.
//
// Behaviour
// - Stage low time from upper nibble count
// - Stage high time from lower nibble count
// - Channel three stage two uses own low
// - Channel two phase offsets, stage two upper
// - Channel three phase offsets, stage two upper
// - Channel two bit5 bypasses stage two
// - Channel two bit4 bypasses stage one
// - Channel three bits 5/4 bypass stages
// - Ignore-sync bit3 set disregards chip sync
// - Channel two bit2 forced level, needs ignore-sync
// - Channel three bit2 forced level, needs ignore-sync
// - Channel two stage two start level bit1
// - Channel two stage one start level bit0
// - Channel three stage two start level bit1
// - Channel three stage one start level bit0
// - Duty correction on unless disable bit set
// - Sync holds static unless both stages bypassed, releases aligned restart
`timescale 1ns/10ps
`default_nettype none
`include "chdiv_params.svh"

module lvds_cmos_channel_dividers (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    input  wire chdiv_pkg::reg_addr_t addr_i,
    input  wire chdiv_pkg::reg_byte_t wr_data_i,
    input  wire logic                 wr_stb_i,
    input  wire logic                 rd_stb_i,
    output var  chdiv_pkg::reg_byte_t rd_data_o,
    input  wire logic                 dist_clk_i,
    input  wire logic                 sync_n_i,
    output var  logic                 ch2_clk_o,
    output var  logic                 ch3_clk_o
);
    import chdiv_pkg::*;

    // -------------------------------------------------------
    // Register file
    // -------------------------------------------------------
    // Index 0 is channel two, index 1 channel three
    // All zero at reset: divide by four, start low
    reg_byte_t cyc1_reg  [2];   // Stage one low/high counts
    reg_byte_t phase_reg [2];   // Phase offsets of both stages
    reg_byte_t cyc2_reg  [2];   // Stage two low/high counts
    reg_byte_t ctrl_reg  [2];   // Bypass, sync, force, start
    reg_byte_t dcc_reg   [2];   // Duty correction disable
    logic [1:0] force_en_reg;   // Per channel force enable
    logic [1:0] out_forced;     // Channel at forced level

    // Software writes; one cycle, no wait
    // Force enable keeps only its two low bits
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 2; i++) begin
                cyc1_reg[i]  <= `REG_RESET_VAL;
                phase_reg[i] <= `REG_RESET_VAL;
                cyc2_reg[i]  <= `REG_RESET_VAL;
                ctrl_reg[i]  <= `REG_RESET_VAL;
                dcc_reg[i]   <= `REG_RESET_VAL;
            end
            force_en_reg <= 2'h0;
        end else if (wr_stb_i) begin
            unique case (addr_i)
                `CH2_STAGE1_CYCLE_COUNTS_OFS: begin
                    cyc1_reg[0] <= wr_data_i;
                end
                `CH2_PHASE_OFFSETS_OFS: begin
                    phase_reg[0] <= wr_data_i;
                end
                `CH2_STAGE2_CYCLE_COUNTS_OFS: begin
                    cyc2_reg[0] <= wr_data_i;
                end
                `CH2_CONTROL_OFS: begin
                    ctrl_reg[0] <= wr_data_i;
                end
                `CH2_DUTY_CORRECTION_OFS: begin
                    dcc_reg[0] <= wr_data_i;
                end
                `CH3_STAGE1_CYCLE_COUNTS_OFS: begin
                    cyc1_reg[1] <= wr_data_i;
                end
                `CH3_PHASE_OFFSETS_OFS: begin
                    phase_reg[1] <= wr_data_i;
                end
                `CH3_STAGE2_CYCLE_COUNTS_OFS: begin
                    cyc2_reg[1] <= wr_data_i;
                end
                `CH3_CONTROL_OFS: begin
                    ctrl_reg[1] <= wr_data_i;
                end
                `CH3_DUTY_CORRECTION_OFS: begin
                    dcc_reg[1] <= wr_data_i;
                end
                `FORCE_ENABLE_OFS: begin
                    force_en_reg <= wr_data_i[1:0];
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
    end

    // Read data stand one cycle after the strobe, only there
    // Zero outside the slot, so reads can be ORed
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_data_o <= `READ_UNMAPPED_VAL;
        end else if (!rd_stb_i) begin
            rd_data_o <= `READ_UNMAPPED_VAL;
        end else begin
            unique case (addr_i)
                `CH2_STAGE1_CYCLE_COUNTS_OFS: rd_data_o <= cyc1_reg[0];
                `CH2_PHASE_OFFSETS_OFS:       rd_data_o <= phase_reg[0];
                `CH2_STAGE2_CYCLE_COUNTS_OFS: rd_data_o <= cyc2_reg[0];
                `CH2_CONTROL_OFS:             rd_data_o <= ctrl_reg[0];
                `CH2_DUTY_CORRECTION_OFS:     rd_data_o <= dcc_reg[0];
                `CH3_STAGE1_CYCLE_COUNTS_OFS: rd_data_o <= cyc1_reg[1];
                `CH3_PHASE_OFFSETS_OFS:       rd_data_o <= phase_reg[1];
                `CH3_STAGE2_CYCLE_COUNTS_OFS: rd_data_o <= cyc2_reg[1];
                `CH3_CONTROL_OFS:             rd_data_o <= ctrl_reg[1];
                `CH3_DUTY_CORRECTION_OFS:     rd_data_o <= dcc_reg[1];
                `FORCE_ENABLE_OFS: begin
                    // Live forced state shows in bits 3:2
                    rd_data_o <= {4'h0, out_forced, force_en_reg};
                end
                default: rd_data_o <= `READ_UNMAPPED_VAL;
            endcase
        end
    end

    // -------------------------------------------------------
    // Pin filters
    // -------------------------------------------------------
    logic [2:0] dist_sh_reg;    // Distribution clock samples
    logic [2:0] sync_sh_reg;    // Sync pin samples
    logic       dist_lvl_reg;   // Filtered distribution level
    logic       dist_rise_reg;  // One pulse per input rising edge
    logic       sync_act_reg;   // Chip-level sync asserted

    // Three flops; first stage feeds only the second
    // Sync resets high, its idle level, so no
    // false sync follows reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dist_sh_reg <= 3'h0;
            sync_sh_reg <= 3'h7;
        end else begin
            dist_sh_reg <= {dist_sh_reg[1:0], dist_clk_i};
            sync_sh_reg <= {sync_sh_reg[1:0], sync_n_i};
        end
    end

    // A change counts once the second and third agree
    // Limitation: the pin must be slower than sys/4
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dist_lvl_reg  <= 1'b0;
            dist_rise_reg <= 1'b0;
        end else begin
            if (dist_sh_reg[1] == dist_sh_reg[2]) begin
                dist_lvl_reg <= dist_sh_reg[2];
            end
            dist_rise_reg <= (dist_sh_reg[1] == dist_sh_reg[2])
                             && dist_sh_reg[2] && !dist_lvl_reg;
        end
    end

    // Active low pin; asserted while filtered low
    // Channels with ignore-sync set never see it
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync_act_reg <= 1'b0;
        end else if (sync_sh_reg[1] == sync_sh_reg[2]) begin
            sync_act_reg <= !sync_sh_reg[2];
        end
    end

    // -------------------------------------------------------
    // Stage length with optional duty correction
    // -------------------------------------------------------
    // Field value n gives n+1 input cycles. With correction
    // the period is kept and split as evenly as it can be;
    // an odd period leaves the extra cycle on the low side.
    // Widest sum is 32, so six bits never wrap.
    function automatic count_t stage_len(
        input nibble_t hi,
        input nibble_t lo,
        input logic    dcc_on,
        input logic    want_high
    );
        logic [5:0] sum;
        logic [5:0] half;
        sum  = {2'h0, hi} + {2'h0, lo} + 6'h02;
        half = sum >> 1;
        if (dcc_on) begin
            stage_len = want_high ? half[4:0]
                                  : 5'(sum - half);
        end else begin
            stage_len = want_high ? {1'b0, hi} + 5'h01
                                  : {1'b0, lo} + 5'h01;
        end
    endfunction

    // -------------------------------------------------------
    // Channels and stages
    // -------------------------------------------------------
    logic   st_lvl_reg  [2][2];  // Stage output level
    logic   st_rise_reg [2][2];  // Stage output rising pulse
    count_t st_cnt_reg  [2][2];  // Input edges left in phase
    logic   [1:0] out_lvl;       // Channel output before flop

    // One pass per channel, inner pass per stage

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic hold;              // Channel held by sync
        logic dcc_on;            // Duty correction active
        // Sync only acts on channels that obey it
        assign hold = sync_act_reg
                      && !ctrl_reg[c][`IGNORE_SYNC_BIT];
        // Correction on while disable bit is clear
        assign dcc_on = !dcc_reg[c][`DUTY_CORR_DIS_BIT];
        // Forcing needs ignore-sync set as well
        // and then overrides whatever the stages do
        assign out_forced[c] = force_en_reg[c]
                               && ctrl_reg[c][`IGNORE_SYNC_BIT];
        assign out_lvl[c] = out_forced[c]
                            ? ctrl_reg[c][`FORCE_HIGH_BIT]
                            : st_lvl_reg[c][1];

        for (genvar s = 0; s < 2; s++) begin : g_st
            nibble_t hi;         // High count field
            nibble_t lo;         // Low count field
            nibble_t ph;         // Phase offset field
            logic    byp;        // Stage bypassed
            logic    start;      // Start level
            logic    in_lvl;     // Stage input level
            logic    in_rise;    // Stage input edge
            count_t  len_hi;     // High time in input cycles
            count_t  len_lo;     // Low time in input cycles
            count_t  preload;    // First count after restart

            // Stage two of each channel has its own fields
            assign hi = (s == 0)
                ? cyc1_reg[c][`HIGH_CYCLES_MSB:`HIGH_CYCLES_LSB]
                : cyc2_reg[c][`HIGH_CYCLES_MSB:`HIGH_CYCLES_LSB];
            assign lo = (s == 0)
                ? cyc1_reg[c][`LOW_CYCLES_MSB:`LOW_CYCLES_LSB]
                : cyc2_reg[c][`LOW_CYCLES_MSB:`LOW_CYCLES_LSB];
            assign ph = (s == 0)
                ? phase_reg[c][`PHASE_STAGE1_MSB:`PHASE_STAGE1_LSB]
                : phase_reg[c][`PHASE_STAGE2_MSB:`PHASE_STAGE2_LSB];
            assign byp = (s == 0)
                ? ctrl_reg[c][`BYPASS_STAGE1_BIT]
                : ctrl_reg[c][`BYPASS_STAGE2_BIT];
            assign start = (s == 0)
                ? ctrl_reg[c][`START_HIGH_S1_BIT]
                : ctrl_reg[c][`START_HIGH_S2_BIT];

            // Stage one output is stage two's clock
            assign in_lvl  = (s == 0) ? dist_lvl_reg
                                      : st_lvl_reg[c][0];
            assign in_rise = (s == 0) ? dist_rise_reg
                                      : st_rise_reg[c][0];

            assign len_hi  = stage_len(hi, lo, dcc_on, 1'b1);
            assign len_lo  = stage_len(hi, lo, dcc_on, 1'b0);
            // Phase offset delays the first toggle
            // Widest preload is 30, inside five bits
            assign preload = {1'b0, ph}
                             + (start ? len_hi : len_lo) - 5'h01;

            // Level and counter of the stage
            // Bypass wins over sync: a held stage one
            // still shows through a bypassed stage two
            // Counter waits while no input edge arrives
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    st_lvl_reg[c][s] <= 1'b0;
                    st_cnt_reg[c][s] <= 5'h00;
                end else if (byp) begin
                    // Bypassed: input passes straight through
                    st_lvl_reg[c][s] <= in_lvl;
                    st_cnt_reg[c][s] <= preload;
                end else if (hold) begin
                    // Static at the start level until release
                    st_lvl_reg[c][s] <= start;
                    st_cnt_reg[c][s] <= preload;
                end else if (in_rise) begin
                    if (st_cnt_reg[c][s] == 5'h00) begin
                        st_lvl_reg[c][s] <= !st_lvl_reg[c][s];
                        // Reload for the phase now beginning
                        st_cnt_reg[c][s] <= st_lvl_reg[c][s]
                            ? len_lo - 5'h01
                            : len_hi - 5'h01;
                    end else begin
                        st_cnt_reg[c][s] <= st_cnt_reg[c][s] - 5'h01;
                    end
                end
            end

            // Rising pulse of the stage output
            // Stage two counts these pulses, not levels
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    st_rise_reg[c][s] <= 1'b0;
                end else begin
                    st_rise_reg[c][s] <= !hold
                        && (byp ? (in_lvl && !st_lvl_reg[c][s])
                                : (in_rise
                                   && st_cnt_reg[c][s] == 5'h00
                                   && !st_lvl_reg[c][s]));
                end
            end
        end
    end

    // -------------------------------------------------------
    // Output flops
    // -------------------------------------------------------
    // Outputs come straight from flops, one cycle behind
    // The extra cycle buys glitch-free pins
    // whatever the stage and force muxes do
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ch2_clk_o <= 1'b0;
            ch3_clk_o <= 1'b0;
        end else begin
            ch2_clk_o <= out_lvl[0];
            ch3_clk_o <= out_lvl[1];
        end
    end

endmodule

`default_nettype wire

// >>> logic/chdiv_params.svh
// Purpose: Offsets, field positions and reset values of the
//          channel divider block.
// Assumes: Byte-wide registers at word-free offsets.
// Notes:   Definitions only; included by bare name.
`ifndef CHDIV_PARAMS_SVH
`define CHDIV_PARAMS_SVH

// -----------------------------------------------------------
// Register offsets
// -----------------------------------------------------------
`define CH2_STAGE1_CYCLE_COUNTS_OFS 12'h199
`define CH2_PHASE_OFFSETS_OFS       12'h19A
`define CH2_STAGE2_CYCLE_COUNTS_OFS 12'h19B
`define CH2_CONTROL_OFS             12'h19C
`define CH2_DUTY_CORRECTION_OFS     12'h19D
`define CH3_STAGE1_CYCLE_COUNTS_OFS 12'h19E
`define CH3_PHASE_OFFSETS_OFS       12'h19F
`define CH3_STAGE2_CYCLE_COUNTS_OFS 12'h1A0
`define CH3_CONTROL_OFS             12'h1A1
`define CH3_DUTY_CORRECTION_OFS     12'h1A2
`define FORCE_ENABLE_OFS            12'h1A3

// -----------------------------------------------------------
// Field positions
// -----------------------------------------------------------
`define LOW_CYCLES_MSB      7
`define LOW_CYCLES_LSB      4
`define HIGH_CYCLES_MSB     3
`define HIGH_CYCLES_LSB     0
`define PHASE_STAGE2_MSB    7
`define PHASE_STAGE2_LSB    4
`define PHASE_STAGE1_MSB    3
`define PHASE_STAGE1_LSB    0
`define BYPASS_STAGE2_BIT   5
`define BYPASS_STAGE1_BIT   4
`define IGNORE_SYNC_BIT     3
`define FORCE_HIGH_BIT      2
`define START_HIGH_S2_BIT   1
`define START_HIGH_S1_BIT   0
`define DUTY_CORR_DIS_BIT   0

// -----------------------------------------------------------
// Reset values
// -----------------------------------------------------------
`define REG_RESET_VAL       8'h00
`define READ_UNMAPPED_VAL   8'h00

`endif

// >>> logic/chdiv_pkg.sv
// Purpose: Types shared by the channel divider block.
// Assumes: Constants live in chdiv_params.svh.
// Notes:   No numbers here beyond type widths.
package chdiv_pkg;
    typedef logic [11:0] reg_addr_t;  // Register address
    typedef logic [7:0]  reg_byte_t;  // Register data byte
    typedef logic [3:0]  nibble_t;    // Cycle count or phase field
    typedef logic [4:0]  count_t;     // Stage cycle counter
endpackage

// >>> sim/chdiv_monitor.sv
// Purpose: Port-level checks of the channel divider block.
// Assumes: Register writes are shadowed here to know each mode.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
`include "chdiv_params.svh"
module chdiv_monitor (
    input wire logic                 sys_clk_i,
    input wire logic                 rst_i,
    input wire chdiv_pkg::reg_addr_t addr_i,
    input wire chdiv_pkg::reg_byte_t wr_data_i,
    input wire logic                 wr_stb_i,
    input wire logic                 rd_stb_i,
    input wire chdiv_pkg::reg_byte_t rd_data_o,
    input wire logic                 dist_clk_i,
    input wire logic                 sync_n_i,
    input wire logic                 ch2_clk_o,
    input wire logic                 ch3_clk_o
);
    import chdiv_pkg::*;
    // -------------------------------------------------------
    // Shadow state
    // -------------------------------------------------------
    reg_byte_t   shadow_reg [10]; // Copy of every mapped byte but force enable
    logic [1:0]  force_en_reg;    // Copy of force enables
    logic [3:0]  quiet_reg;       // Cycles since the last write
    logic [3:0]  sync_age_reg;    // Cycles since sync pin moved
    logic        sync_last_reg;   // Sync pin one cycle ago
    reg_byte_t   rd_exp_reg;      // Byte a plain read must return
    logic [11:0] idx_w;           // Offset into the shadow
    logic        map_w;           // Address within the shadow
    logic        settled_w;       // Filters and modes have settled
    reg_byte_t   ctl2_w;          // Channel two control
    reg_byte_t   ctl3_w;          // Channel three control
    assign idx_w     = addr_i - `CH2_STAGE1_CYCLE_COUNTS_OFS;
    assign map_w     = (addr_i >= `CH2_STAGE1_CYCLE_COUNTS_OFS) &&
                       (addr_i <= `CH3_DUTY_CORRECTION_OFS);
    assign settled_w = (quiet_reg >= 4'h8) && (sync_age_reg >= 4'h8);
    assign ctl2_w    = shadow_reg[3];
    assign ctl3_w    = shadow_reg[8];
    // Writes land one edge later, as in the register file
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 10; i++) shadow_reg[i] <= 8'h00;
            force_en_reg <= 2'h0;
        end else if (wr_stb_i) begin
            if (map_w) shadow_reg[idx_w[3:0]] <= wr_data_i;
            if (addr_i == `FORCE_ENABLE_OFS) force_en_reg <= wr_data_i[1:0];
        end
    end
    // Saturating ages keep the mode checks off transients
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || wr_stb_i) quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
        sync_last_reg <= sync_n_i;
        if (rst_i || (sync_n_i != sync_last_reg)) sync_age_reg <= 4'h0;
        else if (sync_age_reg != 4'hF) sync_age_reg <= sync_age_reg + 4'h1;
        rd_exp_reg <= map_w ? shadow_reg[idx_w[3:0]] : 8'h00;
    end
    // -------------------------------------------------------
    // Assertions
    // -------------------------------------------------------
    property p_rd_idle;
        @(posedge sys_clk_i) disable iff (rst_i)
        !rd_stb_i |=> rd_data_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside the read slot");
    property p_rd_back;
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_stb_i && (addr_i != `FORCE_ENABLE_OFS) |=> rd_data_o == rd_exp_reg;
    endproperty
    a_rd_back: assert property (p_rd_back)
        else $error("read data differs from the written byte");
    property p_rd_force;
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_stb_i && (addr_i == `FORCE_ENABLE_OFS)
            |=> rd_data_o[7:4] == 4'h0 && rd_data_o[1:0] == force_en_reg;
    endproperty
    a_rd_force: assert property (p_rd_force)
        else $error("force enable read back wrong");
    property p_force2;
        @(posedge sys_clk_i) disable iff (rst_i)
        settled_w && force_en_reg[0] && ctl2_w[3] |-> ch2_clk_o == ctl2_w[2];
    endproperty
    a_force2: assert property (p_force2)
        else $error("channel two not at its forced level");
    property p_force3;
        @(posedge sys_clk_i) disable iff (rst_i)
        settled_w && force_en_reg[1] && ctl3_w[3] |-> ch3_clk_o == ctl3_w[2];
    endproperty
    a_force3: assert property (p_force3)
        else $error("channel three not at its forced level");
    property p_hold2;
        @(posedge sys_clk_i) disable iff (rst_i)
        settled_w && !sync_n_i && !ctl2_w[3] && !(ctl2_w[5] && ctl2_w[4])
            |-> ch2_clk_o == (ctl2_w[5] ? ctl2_w[0] : ctl2_w[1]);
    endproperty
    a_hold2: assert property (p_hold2)
        else $error("channel two not static at start level in sync");
    property p_hold3;
        @(posedge sys_clk_i) disable iff (rst_i)
        settled_w && !sync_n_i && !ctl3_w[3] && !(ctl3_w[5] && ctl3_w[4])
            |-> ch3_clk_o == (ctl3_w[5] ? ctl3_w[0] : ctl3_w[1]);
    endproperty
    a_hold3: assert property (p_hold3)
        else $error("channel three not static at start level in sync");
    property p_byp2;
        @(posedge sys_clk_i) disable iff (rst_i)
        settled_w && ctl2_w[5] && ctl2_w[4] && ctl2_w[3] && !force_en_reg[0]
            && $rose(dist_clk_i) |-> ##7 $rose(ch2_clk_o);
    endproperty
    a_byp2: assert property (p_byp2)
        else $error("channel two does not follow its input in bypass");
    property p_byp3;
        @(posedge sys_clk_i) disable iff (rst_i)
        settled_w && ctl3_w[5] && ctl3_w[4] && ctl3_w[3] && !force_en_reg[1]
            && $rose(dist_clk_i) |-> ##7 $rose(ch3_clk_o);
    endproperty
    a_byp3: assert property (p_byp3)
        else $error("channel three does not follow its input in bypass");
endmodule
bind lvds_cmos_channel_dividers chdiv_monitor i_monitor (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .addr_i    (addr_i),
    .wr_data_i (wr_data_i),
    .wr_stb_i  (wr_stb_i),
    .rd_stb_i  (rd_stb_i),
    .rd_data_o (rd_data_o),
    .dist_clk_i(dist_clk_i),
    .sync_n_i  (sync_n_i),
    .ch2_clk_o (ch2_clk_o),
    .ch3_clk_o (ch3_clk_o)
);
`default_nettype wire

// >>> sim/clock_load_model.sv
// Purpose: Clock load that times the high and low runs it sees.
// Assumes: Sampled on the system clock, far faster than the load.
// Notes:   Reports the last complete run of each level.
`timescale 1ns/10ps
`default_nettype none
module clock_load_model (
    input  wire logic        sys_clk_i,
    input  wire logic        clk_in_i,
    output var  logic [15:0] hi_len_o,
    output var  logic [15:0] lo_len_o
);
    logic        last_reg = 1'b0; // Level one sample ago
    logic [15:0] run_reg  = '0;   // Samples at the current level
    // A run closes when the level moves; partial runs never show
    always @(posedge sys_clk_i) begin
        if (clk_in_i != last_reg) begin
            if (last_reg) hi_len_o <= run_reg;
            else lo_len_o <= run_reg;
            run_reg <= 16'h1;
        end else begin
            run_reg <= run_reg + 16'h1;
        end
        last_reg <= clk_in_i;
    end
endmodule
`default_nettype wire

// >>> sim/test_lvds_cmos_channel_dividers.sv
// Purpose: Self-checking bench of the channel divider block.
// Assumes: Distribution clock at one sixteenth of the system clock.
// Notes:   Run lengths are in system cycles, 16 per input cycle.
`timescale 1ns/10ps
`default_nettype none
`include "chdiv_params.svh"
module test_lvds_cmos_channel_dividers;
    import chdiv_pkg::*;
    logic        sys_clk_i = 0, rst_i = 1, wr_stb_i = 0, rd_stb_i = 0;
    logic        dist_clk_i = 0, sync_n_i = 1, rd_seen = 0;
    reg_addr_t   addr_i = '0;
    reg_byte_t   wr_data_i = '0, rd_data_o, exp_q [$];
    logic        ch2_clk_o, ch3_clk_o;
    logic [15:0] hi2, lo2, hi3, lo3; // Runs seen by the loads
    int          n_errors = 0, checks = 0, dcnt = 0;
    int          seed = 32'ha0a5f613;
    always #50 sys_clk_i = ~sys_clk_i;
    // Input clock toggles every 8 cycles, well under the edge limit
    always @(posedge sys_clk_i) begin
        dcnt <= (dcnt + 1) % 8;
        if (dcnt == 7) dist_clk_i <= ~dist_clk_i;
    end
    lvds_cmos_channel_dividers i_dut (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o),
        .dist_clk_i(dist_clk_i), .sync_n_i(sync_n_i),
        .ch2_clk_o(ch2_clk_o), .ch3_clk_o(ch3_clk_o));
    clock_load_model i_load2 (.sys_clk_i(sys_clk_i), .clk_in_i(ch2_clk_o),
        .hi_len_o(hi2), .lo_len_o(lo2));
    clock_load_model i_load3 (.sys_clk_i(sys_clk_i), .clk_in_i(ch3_clk_o),
        .hi_len_o(hi3), .lo_len_o(lo3));
    task check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input reg_addr_t a, input reg_byte_t d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_stb_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_stb_i <= 1'b0;
    endtask
    task rd(input reg_addr_t a, input reg_byte_t e);
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_stb_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_stb_i <= 1'b0;
    endtask
    // Read data stand only in the slot after the read edge
    always @(posedge sys_clk_i) begin
        if (rd_seen) check("read data", rd_data_o, exp_q.pop_front());
        rd_seen <= rd_stb_i;
    end
    // Same setup on both channels, then time the steady runs
    task run(input reg_byte_t s1, s2, ctl, dcc, input logic [15:0] h, l);
        reg_addr_t b;
        for (int c = 0; c < 2; c++) begin
            b = c ? `CH3_STAGE1_CYCLE_COUNTS_OFS : `CH2_STAGE1_CYCLE_COUNTS_OFS;
            wr(b, s1);
            wr(b + 12'h1, 8'h00);
            wr(b + 12'h2, s2);
            wr(b + 12'h3, ctl);
            wr(b + 12'h4, dcc);
        end
        repeat (600) @(posedge sys_clk_i);
        check("ch2 high run", hi2, h);
        check("ch2 low run", lo2, l);
        check("ch3 high run", hi3, h);
        check("ch3 low run", lo3, l);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        print_verdict();
    end
    initial begin
        reg_byte_t d;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Random bytes through every mapped register but force enable
        for (int i = 0; i < 10; i++) begin
            d = 8'($random(seed));
            wr(12'h199 + 12'(i), d);
            rd(12'h199 + 12'(i), d);
        end
        wr(12'h000, 8'hFF);
        rd(12'h000, 8'h00);
        // Forced levels need the ignore-sync bit as well
        wr(`FORCE_ENABLE_OFS, 8'h03);
        wr(`CH2_CONTROL_OFS, 8'h0C);
        wr(`CH3_CONTROL_OFS, 8'h08);
        repeat (20) @(posedge sys_clk_i);
        check("ch2 forced", ch2_clk_o, 1'b1);
        check("ch3 forced", ch3_clk_o, 1'b0);
        rd(`FORCE_ENABLE_OFS, 8'h0F);
        // Sync held: obeying channels sit at their start level
        wr(`FORCE_ENABLE_OFS, 8'h00);
        wr(`CH2_CONTROL_OFS, 8'h02);
        wr(`CH3_CONTROL_OFS, 8'h01);
        sync_n_i <= 1'b0;
        repeat (40) @(posedge sys_clk_i);
        check("ch2 held", ch2_clk_o, 1'b1);
        check("ch3 held", ch3_clk_o, 1'b0);
        run(8'h00, 8'h00, 8'h38, 8'h01, 16'd8, 16'd8);
        sync_n_i <= 1'b1;
        run(8'h21, 8'h00, 8'h28, 8'h01, 16'd32, 16'd48);
        run(8'h00, 8'h30, 8'h18, 8'h01, 16'd16, 16'd64);
        run(8'h00, 8'h10, 8'h08, 8'h01, 16'd32, 16'd64);
        run(8'h00, 8'h30, 8'h18, 8'h00, 16'd32, 16'd48);
        repeat (4) @(posedge sys_clk_i);
        print_verdict();
    end
endmodule
`default_nettype wire
